// ==== hw/mbc_regs.vh ====
// register map, reset values and field positions of the baud clock generator
`ifndef MBC_REGS_VH
`define MBC_REGS_VH
// register indexes; byte address is index times four
`define MBC_IDX_PORT3_DIR 16'hFF23
`define MBC_IDX_PORT3_LATCH 16'hFF03
`define MBC_IDX_GEN_CTRL 16'hFF4C
`define MBC_IDX_BASE_SEL 16'hFF4D
`define MBC_IDX_BAUD_DIV 16'hFF4E
`define MBC_IDX_PORT3_BITOP 16'hFF50
// reset values
`define MBC_RST_PORT3_DIR 8'hFF
`define MBC_RST_PORT3_LATCH 8'h00
`define MBC_RST_GEN_CTRL 8'h10
`define MBC_RST_BASE_SEL 8'h00
`define MBC_RST_BAUD_DIV 8'h1F
// field positions and masks
`define MBC_CTRL_ENABLE_BIT 7
`define MBC_CTRL_WMASK 8'h93
`define MBC_SEL_WMASK 8'h07
`define MBC_DIV_WMASK 8'h1F
`define MBC_DIR_WMASK 8'h1F
`define MBC_DIR_FIXED 8'hE0
`define MBC_BITOP_VAL_BIT 3
`define MBC_DIV_MIN 5'h04
`endif

// ==== hw/mbc_div_counter.v ====
// modulo-k counter that pulses once every k input ticks
`timescale 1ns/1ps
`default_nettype none
module mbc_div_counter
#(
  parameter WIDTH = 5
)
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // control
  input wire i_clear,
  input wire i_tick,
  input wire [WIDTH-1:0] i_limit,
  // result
  output reg o_pulse_ff
);
  reg [WIDTH-1:0] count_ff;
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_ff <= {WIDTH{1'b0}};
      o_pulse_ff <= 1'b0;
    end
    else if (i_clear)
    begin
      count_ff <= {WIDTH{1'b0}};
      o_pulse_ff <= 1'b0;
    end
    else if (i_tick)
    begin
      if (count_ff >= i_limit - {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        count_ff <= {WIDTH{1'b0}};
        o_pulse_ff <= 1'b1;
      end
      else
      begin
        count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        o_pulse_ff <= 1'b0;
      end
    end
    else
    begin
      o_pulse_ff <= 1'b0;
    end
  end
endmodule // mbc_div_counter
`default_nettype wire

// ==== hw/mbc_baud_gen.v ====
// baud clock generator with apb register file and port-3 direction control
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mbc_regs.vh"
// Overview of operation
// - base clock is peripheral clock over 2^select, with select codes 6 and 7 acting as 5
// - select register resets zero, byte writes only
// - divide base clock by k, minimum four
// - extra divide by two makes baud clock
// - divisor resets to 1F, byte writes only
// - direction zero drives pin, one releases
// - direction resets all ones, bit or byte writes
// - enable bit seven stops or runs generator
module mbc_baud_gen
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // generator
  output reg o_baud_clk,
  output reg o_generator_enable,
  output reg [7:0] o_generator_control,
  // port 3 pins 0 to 4
  output reg [4:0] o_port3_oe,
  output reg [4:0] o_port3_latch
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_ff;
  reg [7:0] sel_ff;
  reg [7:0] div_ff;
  reg [7:0] dir_ff;
  reg [7:0] latch_ff;
  reg [4:0] pre_ff;
  reg [7:0] nxt_ctrl;
  reg [7:0] nxt_sel;
  reg [7:0] nxt_div;
  reg [7:0] nxt_dir;
  reg [7:0] nxt_latch;
  reg [31:0] rd_mux;
  reg hit;
  reg base_tick;
  wire k_pulse;
  wire [4:0] k_limit;
  wire commit;
  wire run;

  wire [7:0] wbyte = i_pwdata[7:0];
  wire [2:0] bit_sel = i_pwdata[2:0];
  wire is_ctrl = (i_paddr == {14'h0000, `MBC_IDX_GEN_CTRL, 2'b00});
  wire is_sel = (i_paddr == {14'h0000, `MBC_IDX_BASE_SEL, 2'b00});
  wire is_div = (i_paddr == {14'h0000, `MBC_IDX_BAUD_DIV, 2'b00});
  wire is_dir = (i_paddr == {14'h0000, `MBC_IDX_PORT3_DIR, 2'b00});
  wire is_latch = (i_paddr == {14'h0000, `MBC_IDX_PORT3_LATCH, 2'b00});
  wire is_bitop = (i_paddr == {14'h0000, `MBC_IDX_PORT3_BITOP, 2'b00});

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state so that read data and ready come from flip-flops
  // writes without the lane zero strobe are dropped, with no error
  assign commit = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];

  // bit-op address is write-only and reads back zero
  always @*
  begin
    hit = is_ctrl | is_sel | is_div | is_dir | is_latch | is_bitop;
    rd_mux = 32'h0000_0000;
    if (is_ctrl)
      rd_mux = {24'h000000, ctrl_ff};
    else if (is_sel)
      rd_mux = {24'h000000, sel_ff};
    else if (is_div)
      rd_mux = {24'h000000, div_ff};
    else if (is_dir)
      rd_mux = {24'h000000, dir_ff};
    else if (is_latch)
      rd_mux = {24'h000000, latch_ff};
  end

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_ctrl = ctrl_ff;
    nxt_sel = sel_ff;
    nxt_div = div_ff;
    nxt_dir = dir_ff;
    nxt_latch = latch_ff;
    if (commit)
    begin
      if (is_ctrl)
        nxt_ctrl = wbyte & `MBC_CTRL_WMASK;
      if (is_sel)
        nxt_sel = wbyte & `MBC_SEL_WMASK;
      if (is_div)
        nxt_div = wbyte & `MBC_DIV_WMASK;
      if (is_dir)
        nxt_dir = (wbyte & `MBC_DIR_WMASK) | `MBC_DIR_FIXED;
      if (is_latch)
        nxt_latch = wbyte & `MBC_DIR_WMASK;
      if (is_bitop && bit_sel < 3'h5)
        nxt_dir[bit_sel] = i_pwdata[`MBC_BITOP_VAL_BIT];
    end
  end

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_ff <= `MBC_RST_GEN_CTRL;
      sel_ff <= `MBC_RST_BASE_SEL;
      div_ff <= `MBC_RST_BAUD_DIV;
      dir_ff <= `MBC_RST_PORT3_DIR;
      latch_ff <= `MBC_RST_PORT3_LATCH;
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_generator_enable <= 1'b0;
      o_generator_control <= `MBC_RST_GEN_CTRL;
      o_port3_oe <= 5'h00;
      o_port3_latch <= 5'h00;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      sel_ff <= nxt_sel;
      div_ff <= nxt_div;
      dir_ff <= nxt_dir;
      latch_ff <= nxt_latch;
      o_pready <= i_psel & i_penable & ~o_pready;
      o_prdata <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_mux : 32'h0000_0000;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
      o_generator_enable <= nxt_ctrl[`MBC_CTRL_ENABLE_BIT];
      o_generator_control <= nxt_ctrl;
      o_port3_oe <= ~nxt_dir[4:0];
      o_port3_latch <= nxt_latch[4:0];
    end
  end

  // ----------------------------------------------------------------
  // clock division
  // ----------------------------------------------------------------
  // select and divisor are not guarded while running;
  // software stops the generator before changing them
  // stopped generator holds dividers cleared
  assign run = ctrl_ff[`MBC_CTRL_ENABLE_BIT];

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      pre_ff <= 5'h00;
    else if (!run)
      pre_ff <= 5'h00;
    else
      pre_ff <= pre_ff + 5'h01;
  end

  // prescaler tap select
  // prohibited codes fall back to the slowest tap
  always @*
  begin
    case (sel_ff[2:0])
      3'h0: base_tick = run;
      3'h1: base_tick = run & pre_ff[0];
      3'h2: base_tick = run & (&pre_ff[1:0]);
      3'h3: base_tick = run & (&pre_ff[2:0]);
      3'h4: base_tick = run & (&pre_ff[3:0]);
      default: base_tick = run & (&pre_ff[4:0]);
    endcase
  end

  // codes below four give k of four
  assign k_limit = (div_ff[4:0] < `MBC_DIV_MIN) ? `MBC_DIV_MIN : div_ff[4:0];

  // clear follows run, so a restart begins with a full period
  mbc_div_counter #(.WIDTH(5)) u_kdiv
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_clear(~run),
    .i_tick(base_tick),
    .i_limit(k_limit),
    .o_pulse_ff(k_pulse)
  );

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_baud_clk <= 1'b0;
    else if (!run)
      o_baud_clk <= 1'b0;
    else if (k_pulse)
      o_baud_clk <= ~o_baud_clk;
  end
endmodule // mbc_baud_gen
`default_nettype wire

// ==== test/mbc_baud_gen_sva.sv ====
// port checker for the baud clock generator
`timescale 1ns/1ps
`default_nettype none
module mbc_baud_gen_chk
(
  // watched ports
  input wire i_mclk,
  input wire i_rst,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire o_baud_clk,
  input wire o_generator_enable,
  input wire [7:0] o_generator_control
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire rd = o_pready && !i_pwrite;
  stop_low_a: assert property
    (!o_generator_enable [*2] |-> !o_baud_clk) else $error("baud runs while stopped");
  en_bit_a: assert property
    (o_generator_enable == o_generator_control[7]) else $error("enable not bit 7");
  rise_en_a: assert property
    ($rose(o_baud_clk) |-> $past(o_generator_enable)) else $error("rise while stopped");
  high_min_a: assert property
    ($rose(o_baud_clk) |=> o_baud_clk [*3]) else $error("high phase too short");
  low_min_a: assert property
    ($fell(o_baud_clk) |=> !o_baud_clk [*3]) else $error("low phase too short");
  sel_top_a: assert property
    (rd && i_paddr == 32'h0003FD34 |-> o_prdata[31:3] == 29'h0) else $error("select top bits");
  div_top_a: assert property
    (rd && i_paddr == 32'h0003FD38 |-> o_prdata[31:5] == 27'h0) else $error("divisor top bits");
  err_rdy_a: assert property
    (o_pslverr |-> o_pready) else $error("error without ready");
endmodule // mbc_baud_gen_chk
bind mbc_baud_gen mbc_baud_gen_chk chk_u (.i_mclk, .i_rst, .i_pwrite, .i_paddr, .o_pready,
  .o_prdata, .o_pslverr, .o_baud_clk, .o_generator_enable, .o_generator_control);
`default_nettype wire

// ==== test/tb_mbc_baud_gen.sv ====
// self-checking bench for the baud clock generator
`timescale 1ns/1ps
`default_nettype none
`include "mbc_regs.vh"
module tb_mbc_baud_gen;
  localparam [31:0] A_DIR = `MBC_IDX_PORT3_DIR * 4;
  localparam [31:0] A_LAT = `MBC_IDX_PORT3_LATCH * 4;
  localparam [31:0] A_CTL = `MBC_IDX_GEN_CTRL * 4;
  localparam [31:0] A_SEL = `MBC_IDX_BASE_SEL * 4;
  localparam [31:0] A_DIV = `MBC_IDX_BAUD_DIV * 4;
  localparam [31:0] A_BOP = `MBC_IDX_PORT3_BITOP * 4;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, rdat, d;
  logic [3:0] i_pstrb = 4'hF;
  logic rerr;
  wire o_pready, o_pslverr, o_baud_clk, o_generator_enable;
  wire [31:0] o_prdata;
  wire [7:0] o_generator_control;
  wire [4:0] o_port3_oe, o_port3_latch;
  integer error_cnt = 0, total_checks = 0, seed = 1, i;
  mbc_baud_gen dut_u (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .o_baud_clk, .o_generator_enable,
    .o_generator_control, .o_port3_oe, .o_port3_latch);
  always #2 i_mclk = ~i_mclk;
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // every wait in apb and till runs through here, so a hang ends the run
  task tick(inout integer n);
    begin
      @(posedge i_mclk);
      n = n + 1;
      if (n > 5000)
      begin
        error_cnt = error_cnt + 1;
        tally_and_finish;
      end
    end
  endtask
  // idle edge at the end keeps back-to-back calls from clashing
  task apb(input logic w, input logic [31:0] a, input logic [31:0] v);
    integer n;
    begin
      n = 0;
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= v;
      tick(n);
      i_penable <= 1'h1;
      do tick(n); while (o_pready !== 1'h1);
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      tick(n);
    end
  endtask
  function integer per(input logic [2:0] s, input logic [4:0] c);
    per = 2 * (c < 5'h04 ? 4 : c) << s;
  endfunction
  task till(input logic v, inout integer n);
    do tick(n); while (o_baud_clk !== v);
  endtask
  task baud(input logic [2:0] s, input logic [4:0] c);
    integer n;
    begin
      apb(1'h1, A_CTL, 32'h0);
      apb(1'h1, A_SEL, {29'h0, s});
      apb(1'h1, A_DIV, {27'h0, c});
      apb(1'h1, A_CTL, 32'h80);
      chk(o_generator_control, 32'h80);
      n = 0;
      till(1'h1, n);
      n = 0;
      till(1'h0, n);
      till(1'h1, n);
      chk(n, per(s, c));
    end
  endtask
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(posedge i_mclk);
    apb(1'h0, A_DIR, 32'h0);
    chk(rdat, 32'hFF);
    chk(rerr, 1'h0);
    apb(1'h0, A_SEL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'h0, A_DIV, 32'h0);
    chk(rdat, 32'h1F);
    apb(1'h0, A_CTL, 32'h0);
    chk(rdat, 32'h10);
    apb(1'h1, A_CTL, 32'h7F);
    apb(1'h0, A_CTL, 32'h0);
    chk(rdat, 32'h13);
    chk(o_generator_control, 32'h13);
    chk(o_generator_enable, 1'h0);
    apb(1'h1, A_SEL, 32'hFF);
    apb(1'h0, A_SEL, 32'h0);
    chk(rdat, 32'h7);
    // write without the lane zero strobe must not land
    i_pstrb <= 4'hE;
    apb(1'h1, A_SEL, 32'h2);
    i_pstrb <= 4'hF;
    apb(1'h0, A_SEL, 32'h0);
    chk(rdat, 32'h7);
    apb(1'h1, A_DIV, 32'hFF);
    apb(1'h0, A_DIV, 32'h0);
    chk(rdat, 32'h1F);
    apb(1'h0, 32'h0, 32'h0);
    chk(rerr, 1'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      d = $random(seed);
      apb(1'h1, A_DIR, d);
      apb(1'h0, A_DIR, 32'h0);
      chk(rdat, {24'h0, 3'h7, d[4:0]});
      chk(o_port3_oe, {27'h0, ~d[4:0]});
    end
    apb(1'h1, A_DIR, 32'hFF);
    apb(1'h1, A_LAT, 32'hFF);
    chk(o_port3_latch, 32'h1F);
    apb(1'h1, A_LAT, 32'h0);
    apb(1'h1, A_BOP, 32'h2);
    apb(1'h0, A_DIR, 32'h0);
    chk(rdat, 32'hFB);
    chk(o_port3_oe, 32'h4);
    chk(o_port3_latch, 32'h0);
    baud(3'h0, 5'h02);
    baud(3'h1, 5'h1F);
    baud(3'h5, 5'h04);
    for (i = 0; i < 3; i = i + 1)
      baud($unsigned($random(seed)) % 6, $random(seed));
    apb(1'h1, A_CTL, 32'h0);
    // baud clears one edge after the enable bit drops
    @(posedge i_mclk);
    chk(o_baud_clk, 1'h0);
    chk(o_generator_enable, 1'h0);
    tally_and_finish;
  end
endmodule // tb_mbc_baud_gen
`default_nettype wire
